// ### verification/gsp_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gsp_asserts
  import gsp_pkg::*;
#(
  parameter int FIFO_DEPTH = GSP_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic reference_clock_in_i,
  input wire logic interface_width_select_i,
  input wire logic recv_clock_rate_select_i,
  input wire logic comma_align_enable_i,
  input wire logic [GSP_WORD_W-1:0] transmit_word_bits_i,
  input wire logic tx_ready_o,
  input wire logic serial_out_pos_o,
  input wire logic serial_out_neg_o,
  input wire logic serial_out_oe_n_o,
  input wire logic serial_in_pos_i,
  input wire logic serial_in_neg_i,
  input wire logic [GSP_WORD_W-1:0] receive_word_bits_o,
  input wire logic recv_byte_clock_a_o,
  input wire logic recv_byte_clock_b_o,
  input wire logic comma_detect_o
);
  // ****************
  // Port checks
  // ****************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  logic full_clk;
  logic no_sync;
  // Mode inputs only move under reset, so their raw level stands for the synced one
  assign full_clk = recv_clock_rate_select_i || interface_width_select_i;
  assign no_sync = !comma_align_enable_i;

  AST_RESET_CLOCKS_LOW: assert property (
    $fell(reset_i) |-> !recv_byte_clock_a_o && !recv_byte_clock_b_o)
    else $error("byte clocks not low in reset");
  AST_RESET_TX_UNDRIVEN: assert property (
    $fell(reset_i) |-> serial_out_oe_n_o)
    else $error("serial pair driven in reset");
  AST_DRIVE_STAYS: assert property (
    !serial_out_oe_n_o |=> !serial_out_oe_n_o)
    else $error("serial drive released");
  AST_DIFF_PAIR: assert property (
    !serial_out_oe_n_o |-> serial_out_neg_o != serial_out_pos_o)
    else $error("serial pair not complementary");
  AST_SECOND_CLOCK_IDLE: assert property (
    full_clk |-> !recv_byte_clock_b_o)
    else $error("second byte clock active in full rate");
  AST_HALF_OPPOSITE: assert property (
    $changed(recv_byte_clock_b_o) |-> recv_byte_clock_b_o != recv_byte_clock_a_o)
    else $error("half rate clocks in phase");
  AST_FULL_RATE_PHASE: assert property (
    $changed(recv_byte_clock_a_o) && full_clk && no_sync
    |=> $stable(recv_byte_clock_a_o)[*4] ##1 $changed(recv_byte_clock_a_o))
    else $error("full rate clock phase not five cycles");
  AST_HALF_RATE_PHASE: assert property (
    $changed(recv_byte_clock_a_o) && !full_clk && no_sync
    |=> $stable(recv_byte_clock_a_o)[*8] ##1 $stable(recv_byte_clock_a_o)
    ##1 $changed(recv_byte_clock_a_o))
    else $error("half rate clock phase not ten cycles");
  AST_COMMA_WIDTH: assert property (
    $rose(comma_detect_o) |=> comma_detect_o[*8] ##1 comma_detect_o ##1 !comma_detect_o)
    else $error("comma flag not one word long");
  AST_NO_COMMA_WHEN_OFF: assert property (
    no_sync |-> !comma_detect_o)
    else $error("comma flag with alignment off");
  AST_COMMA_ON_CLOCK: assert property (
    $rose(comma_detect_o) && full_clk |-> $rose(recv_byte_clock_a_o))
    else $error("comma flag not on byte clock rise");
endmodule

bind gsp_top gsp_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) asserts_u (
  .clk_sys_i, .reset_i, .ce_i, .reference_clock_in_i, .interface_width_select_i,
  .recv_clock_rate_select_i, .comma_align_enable_i, .transmit_word_bits_i, .tx_ready_o,
  .serial_out_pos_o, .serial_out_neg_o, .serial_out_oe_n_o, .serial_in_pos_i,
  .serial_in_neg_i, .receive_word_bits_o, .recv_byte_clock_a_o, .recv_byte_clock_b_o,
  .comma_detect_o
);
`default_nettype wire

// ### verification/gsp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module gsp_ctrl_model
  import gsp_pkg::*;
(
  input wire logic run_i,
  input wire logic ddr_i,
  output logic ref_clk_o,
  output logic [GSP_WORD_W-1:0] word_o
);
  // ****************
  // Controller side
  // ****************
  int k;
  logic [GSP_WORD_W-1:0] w;
  initial begin
    k = 0;
    ref_clk_o = 1'b0;
    word_o = 10'h155;
    #7;
    forever begin
      if (!run_i) begin
        // Idle lines toggle so a stale word never passes for data
        word_o = ~word_o;
        #160;
      end else begin
        w = {5'(k) ^ 5'h15, ~5'(k)};
        // Upper lines carry the inverted current half in double rate, so they carry noise
        word_o = ddr_i ? {~w[4:0], w[4:0]} : w;
        #40 ref_clk_o = 1'b1;
        #40;
        if (ddr_i) begin
          word_o = {~w[9:5], w[9:5]};
        end
        #40 ref_clk_o = 1'b0;
        #40 k++;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  // ****************
  // Harness
  // ****************
  logic clk_sys_i, reset_i, ce_i, reference_clock_in_i, run;
  logic interface_width_select_i, recv_clock_rate_select_i, comma_align_enable_i;
  logic [gsp_pkg::GSP_WORD_W-1:0] transmit_word_bits_i, receive_word_bits_o;
  logic tx_ready_o, serial_out_pos_o, serial_out_neg_o, serial_out_oe_n_o;
  logic serial_in_pos_i, serial_in_neg_i, recv_byte_clock_a_o, recv_byte_clock_b_o;
  logic comma_detect_o;
  logic rxq[$];
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;

  gsp_top dut_u (
    .clk_sys_i, .reset_i, .ce_i, .reference_clock_in_i, .interface_width_select_i,
    .recv_clock_rate_select_i, .comma_align_enable_i, .transmit_word_bits_i, .tx_ready_o,
    .serial_out_pos_o, .serial_out_neg_o, .serial_out_oe_n_o, .serial_in_pos_i,
    .serial_in_neg_i, .receive_word_bits_o, .recv_byte_clock_a_o, .recv_byte_clock_b_o,
    .comma_detect_o
  );
  gsp_ctrl_model ctrl_u (
    .run_i(run),
    .ddr_i(interface_width_select_i),
    .ref_clk_o(reference_clock_in_i),
    .word_o(transmit_word_bits_i)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Line idles on a toggling pattern, which can never hold a comma
  always @(posedge clk_sys_i) begin
    if (rxq.size() > 0) begin
      serial_in_pos_i <= rxq.pop_front();
    end else begin
      serial_in_pos_i <= ~serial_in_pos_i;
    end
  end
  assign serial_in_neg_i = ~serial_in_pos_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // ****************
  // Scenarios
  // ****************
  function automatic logic [9:0] wd(input int k);
    return {5'(k) ^ 5'h15, ~5'(k)};
  endfunction
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic do_reset(input logic w, input logic r, input logic c);
    @(posedge clk_sys_i);
    run <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b1;
    interface_width_select_i <= w;
    recv_clock_rate_select_i <= r;
    comma_align_enable_i <= c;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    #1;
    `CHK({serial_out_oe_n_o, recv_byte_clock_a_o, recv_byte_clock_b_o}, 3'h4)
  endtask
  task automatic t_tx(input logic ddr);
    int base;
    logic [9:0] e;
    do_reset(ddr, 1'b1, 1'b0);
    base = ctrl_u.k;
    run <= 1'b1;
    repeat (100) begin
      tick();
      if (serial_out_oe_n_o === 1'b0) break;
    end
    // Ref period is shorter than a word, so the shifter never starves here
    for (int i = 0; i < 60; i++) begin
      e = wd(base + i / 10);
      `CHK(serial_out_pos_o, e[i % 10])
      tick();
    end
    run <= 1'b0;
  endtask
  task automatic t_fill();
    logic seen;
    seen = 1'b0;
    do_reset(1'b0, 1'b1, 1'b0);
    run <= 1'b1;
    repeat (480) begin
      tick();
      if (tx_ready_o === 1'b0) begin
        seen = 1'b1;
      end
    end
    run <= 1'b0;
    repeat (150) tick();
    `CHK({seen, tx_ready_o}, 2'h3)
  endtask
  task automatic t_rx(input logic ddr);
    logic [29:0] s;
    s = {10'h2A5, 10'h17C, 10'h2AA};
    do_reset(ddr, 1'b1, 1'b1);
    for (int i = 0; i < 30; i++) begin
      rxq.push_back(s[i]);
    end
    repeat (200) begin
      tick();
      if (comma_detect_o === 1'b1) break;
    end
    `CHK({comma_detect_o, recv_byte_clock_a_o}, 2'h3)
    if (ddr) begin
      `CHK(receive_word_bits_o, 10'h01C)
      repeat (5) tick();
      `CHK({recv_byte_clock_a_o, receive_word_bits_o}, 11'h00B)
    end else begin
      `CHK(receive_word_bits_o, 10'h17C)
      repeat (10) tick();
      `CHK(receive_word_bits_o, 10'h2A5)
    end
  endtask
  task automatic t_half();
    int n;
    n = 0;
    do_reset(1'b0, 1'b0, 1'b0);
    repeat (100) begin
      tick();
      if (recv_byte_clock_b_o === 1'b1) break;
    end
    `CHK(recv_byte_clock_a_o, 1'b0)
    while (recv_byte_clock_b_o === 1'b1 && n < 40) begin
      tick();
      n++;
    end
    `CHK(n, 10)
    repeat (20) tick();
    `CHK({recv_byte_clock_a_o, recv_byte_clock_b_o}, 2'h2)
  endtask
  task automatic wrap_up();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    run = 1'b0;
    interface_width_select_i = 1'b0;
    recv_clock_rate_select_i = 1'b1;
    comma_align_enable_i = 1'b0;
    serial_in_pos_i = 1'b0;
    t_tx(1'b0);
    t_tx(1'b1);
    t_fill();
    t_rx(1'b0);
    t_rx(1'b1);
    t_half();
    wrap_up();
  end
endmodule
`default_nettype wire

// ### verilog/gsp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module gsp_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE = (AW+1)'(1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // ********************************
  // Pointers
  // ********************************
  assign in_ready_o = (cnt_q != DEPTH_CNT);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + ONE;
    end else if (pop && !push) begin
      cnt_d = cnt_q - ONE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; empty flag guards reads
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ### verilog/gsp_pkg.sv
`default_nettype none
package gsp_pkg;
  // ********************************
  // Word layout
  // ********************************
  localparam int GSP_WORD_W = 10;
  localparam int GSP_HALF_W = 5;
  localparam int GSP_CNT_W = 4;

  typedef struct packed {
    logic [GSP_HALF_W-1:0] hi;
    logic [GSP_HALF_W-1:0] lo;
  } gsp_word_t;

  localparam gsp_word_t GSP_WORD_RST = '{hi: 5'h00, lo: 5'h00};

  // ********************************
  // Timing
  // ********************************
  localparam int GSP_CLK_PERIOD_NS = 20;
  localparam int GSP_BIT_MULT = 10;
  localparam int GSP_TX_LAT_MIN_BITS = 19;
  localparam int GSP_TX_LAT_MAX_BITS = 20;
  localparam int GSP_TX_LAT_DDR_MIN_BITS = 30;
  localparam logic [GSP_CNT_W-1:0] GSP_LAST_BIT = 4'h9;
  localparam logic [GSP_CNT_W-1:0] GSP_HALF_BIT = 4'h5;
  localparam logic [GSP_CNT_W-1:0] GSP_COMMA_END_BIT = 4'h6;
  localparam logic [GSP_CNT_W-1:0] GSP_COMMA_NEXT_BIT = 4'h7;
  localparam logic [GSP_CNT_W-1:0] GSP_CNT_RST = 4'h0;

  // ********************************
  // Comma pattern as it sits in the shifter, newest bit on top
  // ********************************
  localparam int GSP_COMMA_W = 7;
  localparam logic [GSP_COMMA_W-1:0] GSP_COMMA_SHIFTED = 7'h7C;

  // ********************************
  // Buffering
  // ********************************
  localparam int GSP_FIFO_DEPTH = 8;

  // ********************************
  // States
  // ********************************
  typedef enum logic [1:0] {
    GSP_TX_IDLE = 2'h0,
    GSP_TX_SHIFT = 2'h1
  } gsp_tx_state_t;

  typedef enum logic [1:0] {
    GSP_RX_HUNT = 2'h0,
    GSP_RX_FRAMED = 2'h1
  } gsp_rx_state_t;
endpackage
`default_nettype wire

// ### verilog/gsp_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Width select low gives 10-bit mode, high gives 5-bit double-rate mode.
// - 10-bit mode captures a whole transmit word on each reference clock rise.
// - Bit shifting runs one bit per system clock; one word per ten clocks.
// - Serial output sends each word bit 0 first, bit 9 last.
// - Double-rate mode uses five low data bits, taken on both reference edges.
// - Bits 0-4 arrive on the rising edge, bits 5-9 on the falling edge.
// - The two halves join into one 10-bit word before serialising.
// - 10-bit mode load to bit 9 sent takes 19 to 20 bit times; the code takes 13 to 14 clocks from the pin edge when its buffer is empty.
// - Double-rate mode load to bit 9 sent takes at least 30 bit times; the code takes 13 to 14 clocks from the falling edge with an empty buffer.
// - Receive data is retimed by the local sampling clock, no forwarded clock.
// - Receiver starts framing by itself, with no prelock phase or command.
// - Receiver deserialises, frames to 10-bit words, outputs them with byte clocks.
// - Both receive byte clocks stay low during reset.
// - Serial transmit pair is undriven while powering up.
// - 10-bit mode rate select: low two half-rate clocks, high one full-rate.
// - Half-rate clocks are opposite in phase; second clock low in full rate.
// - Double-rate receive shows bits 0-4 on clock rise, 5-9 on fall.
// - With alignment enabled, comma 0011111 realigns words and pulses detect flag.
module gsp_top
  import gsp_pkg::*;
#(
  parameter int FIFO_DEPTH = GSP_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic reference_clock_in_i,
  input wire logic interface_width_select_i,
  input wire logic recv_clock_rate_select_i,
  input wire logic comma_align_enable_i,
  input wire logic [GSP_WORD_W-1:0] transmit_word_bits_i,
  output logic tx_ready_o,
  output logic serial_out_pos_o,
  output logic serial_out_neg_o,
  output logic serial_out_oe_n_o,
  input wire logic serial_in_pos_i,
  input wire logic serial_in_neg_i,
  output logic [GSP_WORD_W-1:0] receive_word_bits_o,
  output logic recv_byte_clock_a_o,
  output logic recv_byte_clock_b_o,
  output logic comma_detect_o
);
  // ********************************
  // Pin synchronisers
  // ********************************
  localparam int SYNC_W = GSP_WORD_W + 5;
  logic [SYNC_W-1:0] sync1_q, sync2_q, sync_pins;
  logic ref_d1_q;
  logic ref_s, ddr_s, full_s, align_s, rxb_s;
  logic [GSP_WORD_W-1:0] td_s;

  assign sync_pins = {reference_clock_in_i, interface_width_select_i,
                      recv_clock_rate_select_i, comma_align_enable_i,
                      serial_in_pos_i & ~serial_in_neg_i, transmit_word_bits_i};
  assign {ref_s, ddr_s, full_s, align_s, rxb_s, td_s} = sync2_q;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      ref_d1_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= sync_pins;
      sync2_q <= sync1_q;
      ref_d1_q <= ref_s;
    end
  end

  logic ref_rise, ref_fall;
  assign ref_rise = ref_s && !ref_d1_q;
  assign ref_fall = !ref_s && ref_d1_q;

  // ********************************
  // Transmit capture
  // ********************************
  logic [GSP_HALF_W-1:0] lo_q, lo_d;
  logic have_lo_q, have_lo_d;
  gsp_word_t cap_word;
  logic cap_valid, fifo_in_ready;

  always_comb begin
    lo_d = lo_q;
    have_lo_d = have_lo_q;
    cap_word = gsp_word_t'(td_s);
    cap_valid = 1'b0;
    if (ddr_s) begin
      if (ref_rise) begin
        lo_d = td_s[GSP_HALF_W-1:0];
        have_lo_d = 1'b1;
      end else if (ref_fall && have_lo_q) begin
        cap_word = '{hi: td_s[GSP_HALF_W-1:0], lo: lo_q};
        cap_valid = 1'b1;
        have_lo_d = 1'b0;
      end
    end else begin
      have_lo_d = 1'b0;
      cap_valid = ref_rise;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      lo_q <= '0;
      have_lo_q <= 1'b0;
      tx_ready_o <= 1'b0;
    end else if (ce_i) begin
      lo_q <= lo_d;
      have_lo_q <= have_lo_d;
      tx_ready_o <= fifo_in_ready;
    end
  end

  // ********************************
  // Transmit buffer
  // ********************************
  logic [GSP_WORD_W-1:0] fifo_out;
  logic fifo_out_valid, fifo_pop;

  gsp_fifo #(
    .WIDTH(GSP_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .in_data_i(cap_word),
    .in_valid_i(cap_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop)
  );

  // ********************************
  // Serialiser
  // ********************************
  // One bit per system clock stands in for the tenfold bit clock; the
  // buffer absorbs the rate gap and back-pressures through tx_ready_o
  gsp_tx_state_t tx_st_q, tx_st_d;
  logic [GSP_WORD_W-1:0] tx_sh_q, tx_sh_d;
  logic [GSP_CNT_W-1:0] tx_cnt_q, tx_cnt_d;
  logic tx_bit_d, oe_n_d;

  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_cnt_d = tx_cnt_q;
    fifo_pop = 1'b0;
    oe_n_d = serial_out_oe_n_o;
    tx_bit_d = serial_out_pos_o;
    case (tx_st_q)
      GSP_TX_IDLE: begin
        if (fifo_out_valid) begin
          fifo_pop = 1'b1;
          tx_sh_d = fifo_out;
          tx_cnt_d = GSP_CNT_RST;
          tx_st_d = GSP_TX_SHIFT;
        end
      end
      GSP_TX_SHIFT: begin
        tx_bit_d = tx_sh_q[0];
        oe_n_d = 1'b0;
        tx_sh_d = {1'b0, tx_sh_q[GSP_WORD_W-1:1]};
        tx_cnt_d = tx_cnt_q + 4'h1;
        if (tx_cnt_q == GSP_LAST_BIT) begin
          tx_cnt_d = GSP_CNT_RST;
          if (fifo_out_valid) begin
            fifo_pop = 1'b1;
            tx_sh_d = fifo_out;
          end else begin
            tx_st_d = GSP_TX_IDLE;
          end
        end
      end
      default: begin
        tx_st_d = GSP_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_st_q <= GSP_TX_IDLE;
      tx_sh_q <= '0;
      tx_cnt_q <= GSP_CNT_RST;
      serial_out_pos_o <= 1'b0;
      serial_out_neg_o <= 1'b0;
      serial_out_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_cnt_q <= tx_cnt_d;
      serial_out_pos_o <= tx_bit_d;
      serial_out_neg_o <= ~tx_bit_d;
      serial_out_oe_n_o <= oe_n_d;
    end
  end

  // ********************************
  // Deserialiser and word framing
  // ********************************
  gsp_rx_state_t rx_st_q, rx_st_d;
  logic [GSP_WORD_W-1:0] rx_sh_q, rx_sh_d;
  logic [GSP_CNT_W-1:0] rx_cnt_q, rx_cnt_d;
  logic comma_pend_q, comma_pend_d;
  logic word_done, word_comma, comma_seen;

  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q + 4'h1;
    comma_pend_d = comma_pend_q;
    word_done = 1'b0;
    word_comma = 1'b0;
    rx_sh_d = {rxb_s, rx_sh_q[GSP_WORD_W-1:1]};
    comma_seen = align_s &&
      (rx_sh_d[GSP_WORD_W-1 -: GSP_COMMA_W] == GSP_COMMA_SHIFTED);
    if (comma_seen) begin
      comma_pend_d = 1'b1;
      rx_st_d = GSP_RX_FRAMED;
      if (rx_cnt_q != GSP_COMMA_END_BIT) begin
        // Partial word in flight is dropped so the comma lands on bit 0
        rx_cnt_d = GSP_COMMA_NEXT_BIT;
      end
    end
    if (rx_cnt_q == GSP_LAST_BIT && !(comma_seen && rx_cnt_q != GSP_COMMA_END_BIT)) begin
      word_done = 1'b1;
      word_comma = comma_pend_q;
      comma_pend_d = 1'b0;
      rx_cnt_d = GSP_CNT_RST;
    end
    if (rx_st_q != GSP_RX_HUNT && rx_st_q != GSP_RX_FRAMED) begin
      rx_st_d = GSP_RX_HUNT;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_st_q <= GSP_RX_HUNT;
      rx_sh_q <= '0;
      rx_cnt_q <= GSP_CNT_RST;
      comma_pend_q <= 1'b0;
    end else if (ce_i) begin
      rx_st_q <= rx_st_d;
      rx_sh_q <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
      comma_pend_q <= comma_pend_d;
    end
  end

  // ********************************
  // Receive output and byte clocks
  // ********************************
  // Clocks stall in their state while framing slips, but the word count can jump ahead,
  // so a realign can stretch or shorten the current byte clock phase
  logic [GSP_WORD_W-1:0] rx_word_q, rx_word_d, rd_d;
  logic [GSP_CNT_W-1:0] ph_q, ph_d;
  logic rbc_a_d, rbc_b_d, comma_d, half_tgl_q, half_tgl_d;

  always_comb begin
    rx_word_d = rx_word_q;
    ph_d = (ph_q == GSP_LAST_BIT) ? ph_q : ph_q + 4'h1;
    half_tgl_d = half_tgl_q;
    rd_d = receive_word_bits_o;
    rbc_a_d = recv_byte_clock_a_o;
    rbc_b_d = 1'b0;
    comma_d = comma_detect_o;
    if (word_done) begin
      rx_word_d = rx_sh_d;
      ph_d = GSP_CNT_RST;
      half_tgl_d = ~half_tgl_q;
      comma_d = word_comma;
    end
    if (ddr_s) begin
      if (word_done) begin
        rd_d = {5'h00, rx_sh_d[GSP_HALF_W-1:0]};
        rbc_a_d = 1'b1;
      end else if (ph_q == GSP_HALF_BIT - 4'h1) begin
        rd_d = {5'h00, rx_word_q[GSP_WORD_W-1:GSP_HALF_W]};
        rbc_a_d = 1'b0;
      end
    end else if (full_s) begin
      if (word_done) begin
        rd_d = rx_sh_d;
        rbc_a_d = 1'b1;
      end else if (ph_q == GSP_HALF_BIT - 4'h1) begin
        rbc_a_d = 1'b0;
      end
    end else begin
      // Half rate: one clock edge per word, b rises with even words
      // Clocks wait for the first framed word, so mode settling after
      // reset cannot give a short first phase
      rbc_b_d = recv_byte_clock_b_o;
      if (word_done) begin
        rd_d = rx_sh_d;
        rbc_a_d = half_tgl_d;
        rbc_b_d = ~half_tgl_d;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_word_q <= '0;
      ph_q <= GSP_LAST_BIT;
      half_tgl_q <= 1'b1;
      receive_word_bits_o <= '0;
      recv_byte_clock_a_o <= 1'b0;
      recv_byte_clock_b_o <= 1'b0;
      comma_detect_o <= 1'b0;
    end else if (ce_i) begin
      rx_word_q <= rx_word_d;
      ph_q <= ph_d;
      half_tgl_q <= half_tgl_d;
      receive_word_bits_o <= rd_d;
      recv_byte_clock_a_o <= rbc_a_d;
      recv_byte_clock_b_o <= rbc_b_d;
      comma_detect_o <= comma_d;
    end
  end
endmodule
`default_nettype wire

// ### verilog/unused_never.sv
`default_nettype none
`default_nettype wire
